// File: core/wls_pkg.sv
package wls_pkg;

    // Sizes of the supervised network.
    localparam int NODES        = 4;
    localparam int NODE_W       = 2;
    localparam int OUTS         = 8;
    localparam int OUT_PER_NODE = 2;
    localparam int AIN          = 2;
    localparam int AW           = 16;

    // Register byte offsets.
    localparam logic [7:0] ADDR_POLL   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS  = 8'h04;
    localparam logic [7:0] ADDR_CMD    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_POINT  = 8'h10;
    localparam logic [7:0] ADDR_THRESH = 8'h14;
    localparam logic [7:0] ADDR_RATE   = 8'h18;
    localparam logic [7:0] ADDR_REPORT = 8'h1C;
    localparam logic [7:0] ADDR_OUTS   = 8'h20;
    localparam logic [7:0] ADDR_VALUE  = 8'h24;

    // Default condition flag positions in the flags register.
    localparam int FLG_POWER_UP   = 0;
    localparam int FLG_HOST_LINK  = 1;
    localparam int FLG_GW_LINK    = 2;
    localparam int FLG_NODE_LINK  = 3;
    localparam int FLG_SYNC_LOSS  = 4;
    localparam int FLG_AUTO_RECOV = 5;
    localparam int FLG_HOLD_LAST  = 6;
    localparam int FLG_W          = 7;
    localparam int CMD_ERR_RESET  = 0;
    localparam int REP_COS_BIT    = 16;

    // Reset values.
    localparam logic [15:0] POLL_INT_RST = 16'h03E8;
    localparam logic [7:0]  MAX_BAD_RST  = 8'h07;
    localparam logic [7:0]  RELINK_RST   = 8'h04;
    localparam logic [15:0] RATE_RST     = 16'h0001;

    // Timing: all intervals count in units of one millisecond tick.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {POLL_IDLE, POLL_WAIT} wls_poll_state_t;

    // Poll request towards the radio and its answer.
    typedef struct packed {
        logic              req;
        logic [NODE_W-1:0] node;
    } wls_poll_req_t;

    typedef struct packed {
        logic done;
        logic ok;
    } wls_poll_rsp_t;

    // Whole state of the supervisor.
    typedef struct packed {
        logic                     hready;
        logic [31:0]              hrdata;
        logic                     wr_pend;
        logic [7:0]               wr_addr;
        logic [15:0]              poll_int;
        logic [7:0]               max_bad;
        logic [7:0]               relink;
        logic [FLG_W-1:0]         flags;
        logic [AIN-1:0]           pt_en;
        logic [AIN-1:0]           pt_inv;
        logic [15:0]              thr;
        logic [15:0]              hyst;
        logic [15:0]              delta;
        logic [15:0]              samp_int;
        logic [15:0]              rep_int;
        logic                     cos;
        logic [OUTS-1:0]          def_out;
        logic [OUTS-1:0]          sw_out;
        logic                     pwr_hold;
        logic [13:0]              tick_cnt;
        logic [15:0]              poll_cnt;
        logic [15:0]              samp_cnt;
        logic [15:0]              rep_cnt;
        wls_poll_state_t          pstate;
        wls_poll_req_t            poll;
        logic [NODES-1:0]         fail;
        logic [NODES-1:0][7:0]    bad;
        logic [NODES-1:0][7:0]    good;
        logic [1:0]               rf_sync;
        logic [1:0]               lost_sync;
        logic [OUTS-1:0]          dig_out;
        logic [AIN-1:0][AW-1:0]   last;
        logic [AIN-1:0]           on;
        logic [AIN-1:0]           on_out;
        logic                     report;
        logic                     err_hold;
    } wls_state_t;

endpackage : wls_pkg

// File: core/wls_supervisor.sv
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Gateway starts each poll, one per node per interval, only checking radio.
// - Node link fails when consecutive failed polls reach the maximum bad count.
// - Failed link is restored after the recovery count of consecutive good poll replies.
// - With auto recovery, keep polling a failed node and clear after recovery count.
// - Without auto recovery, link error holds until an explicit reset command.
// - Reset command clears all errors except one set by a failed poll reply in the same cycle; an uncleared error blocks further polling.
// - Gateway link failure flag forces the failed node's outputs to default.
// - Host link flag makes a host timeout force all outputs to default.
// - Node link flag makes our own radio fault force all outputs to default.
// - Sync loss flag makes loss of synchronisation force all outputs to default.
// - Power-up flag loads default values into every output at power-up.
// - One set of condition flags governs every output of the device.
// - Analog value is reported only after changing by delta; zero delta disables it.
// - Analog point turns on at threshold, off below threshold minus hysteresis.
// - Change-of-state mode reports only when an input crosses the threshold.
// - Periodic mode reports status once per report interval.
// - Each enabled input is sampled once per sample interval.
// - A disabled point is ignored whatever its other settings.
// - Hold-last option keeps the last output value instead of the default.
// - Invert option inverts the digital representation of a point.
module wls_supervisor
    import wls_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                   clock,
    input  wire logic                   srst,
    // AHB-Lite slave.
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // Radio poll engine.
    output wls_poll_req_t               poll_out,
    input  wire wls_poll_rsp_t          poll_rsp,
    // Fault sources.
    input  wire logic                   host_timeout,
    input  wire logic                   rf_fault_pin,
    input  wire logic                   sync_lost_pin,
    // Field side.
    input  wire logic [AIN-1:0][AW-1:0] ana_in,
    output logic [OUTS-1:0]             dig_out,
    output logic [AIN-1:0]              ana_on,
    output logic [AIN-1:0][AW-1:0]      ana_value,
    output logic                        report_strobe,
    output logic [NODES-1:0]            link_fail,
    output logic                        error_hold
);

    wls_state_t r;
    wls_state_t next_r;

    logic tick;
    logic err;
    logic do_wr;
    logic node_force;
    logic samp_tick;
    logic rep_tick;
    logic [AW:0] off_sum;
    logic [AW-1:0] diff;
    logic [NODE_W-1:0] grp;

    // Bus outputs except hresp, which is tied low, and flagged status come from the state register.
    assign hreadyout     = r.hready;
    assign hresp         = 1'b0;
    assign hrdata        = r.hrdata;
    assign poll_out      = r.poll;
    assign dig_out       = r.dig_out;
    assign ana_on        = r.on_out;
    assign ana_value     = r.last;
    assign report_strobe = r.report;
    assign link_fail     = r.fail;
    assign error_hold    = r.err_hold;

    // Next state of the whole block.
    always_comb begin
        next_r = r;
        tick = (r.tick_cnt == 14'(TICK_LEN - 1));
        err = |(r.fail & ~{NODES{r.flags[FLG_AUTO_RECOV]}});
        do_wr = r.wr_pend;
        node_force = 1'b0;
        samp_tick = 1'b0;
        rep_tick = 1'b0;
        off_sum = '0;
        diff = '0;
        grp = '0;

        // Zero-wait bus slave: read data is fetched in the address phase.
        next_r.hready = 1'b1;
        next_r.wr_pend = hsel && htrans[1] && hready && hwrite;
        next_r.wr_addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[7:0] == ADDR_POLL) begin
                next_r.hrdata = {r.relink, r.max_bad, r.poll_int};
            end else if (haddr[7:0] == ADDR_FLAGS) begin
                next_r.hrdata = {25'h000_0000, r.flags};
            end else if (haddr[7:0] == ADDR_STATUS) begin
                next_r.hrdata = {16'h0000, r.dig_out, 3'h0, err, r.fail};
            end else if (haddr[7:0] == ADDR_POINT) begin
                next_r.hrdata = {26'h000_0000, r.on_out, r.pt_inv, r.pt_en};
            end else if (haddr[7:0] == ADDR_THRESH) begin
                next_r.hrdata = {r.hyst, r.thr};
            end else if (haddr[7:0] == ADDR_RATE) begin
                next_r.hrdata = {r.samp_int, r.delta};
            end else if (haddr[7:0] == ADDR_REPORT) begin
                next_r.hrdata = {15'h0000, r.cos, r.rep_int};
            end else if (haddr[7:0] == ADDR_OUTS) begin
                next_r.hrdata = {16'h0000, r.def_out, r.sw_out};
            end else if (haddr[7:0] == ADDR_VALUE) begin
                next_r.hrdata = {r.last[1], r.last[0]};
            end else begin
                next_r.hrdata = 32'h0000_0000;
            end
        end

        // Register writes in the data phase; the flags word holds nothing else.
        if (do_wr) begin
            if (r.wr_addr == ADDR_POLL) begin
                {next_r.relink, next_r.max_bad, next_r.poll_int} = hwdata;
            end else if (r.wr_addr == ADDR_FLAGS) begin
                next_r.flags = hwdata[FLG_W-1:0];
            end else if (r.wr_addr == ADDR_POINT) begin
                next_r.pt_en = hwdata[1:0];
                next_r.pt_inv = hwdata[3:2];
            end else if (r.wr_addr == ADDR_THRESH) begin
                {next_r.hyst, next_r.thr} = hwdata;
            end else if (r.wr_addr == ADDR_RATE) begin
                {next_r.samp_int, next_r.delta} = hwdata;
            end else if (r.wr_addr == ADDR_REPORT) begin
                next_r.rep_int = hwdata[15:0];
                next_r.cos = hwdata[REP_COS_BIT];
            end else if (r.wr_addr == ADDR_OUTS) begin
                next_r.sw_out = hwdata[7:0];
                next_r.def_out = hwdata[15:8];
                next_r.pwr_hold = 1'b0;
            end
        end

        // Reset command wipes every error and the counters behind it, save for a node whose poll reply lands in the same cycle.
        if (do_wr && r.wr_addr == ADDR_CMD && hwdata[CMD_ERR_RESET]) begin
            next_r.fail = '0;
            next_r.bad = '0;
            next_r.good = '0;
        end

        // Millisecond tick shared by every interval counter.
        next_r.tick_cnt = tick ? 14'h0000 : r.tick_cnt + 14'h0001;

        // Poll sequencer: one round over all nodes per polling interval.
        next_r.poll.req = 1'b0;
        case (r.pstate)
            POLL_IDLE: begin
                if (tick) begin
                    next_r.poll_cnt = r.poll_cnt + 16'h0001;
                end
                // A pending uncleared error stops any new round from starting.
                if (tick && r.poll_cnt + 16'h0001 >= r.poll_int && !err) begin
                    next_r.poll_cnt = 16'h0000;
                    next_r.poll.req = 1'b1;
                    next_r.poll.node = '0;
                    next_r.pstate = POLL_WAIT;
                end
            end
            POLL_WAIT: begin
                if (tick) begin
                    next_r.poll_cnt = r.poll_cnt + 16'h0001;
                end
                if (poll_rsp.done) begin
                    if (poll_rsp.ok) begin
                        next_r.bad[r.poll.node] = 8'h00;
                        if (r.fail[r.poll.node]) begin
                            next_r.good[r.poll.node] = r.good[r.poll.node] + 8'h01;
                            if (r.good[r.poll.node] + 8'h01 >= r.relink) begin
                                next_r.fail[r.poll.node] = 1'b0;
                                next_r.good[r.poll.node] = 8'h00;
                            end
                        end
                    end else begin
                        next_r.good[r.poll.node] = 8'h00;
                        if (r.bad[r.poll.node] != 8'hFF) begin
                            next_r.bad[r.poll.node] = r.bad[r.poll.node] + 8'h01;
                        end
                        if (r.bad[r.poll.node] + 8'h01 >= r.max_bad) begin
                            next_r.fail[r.poll.node] = 1'b1;
                        end
                    end
                    // Without auto recovery a new failure ends the round at once.
                    if (r.poll.node == NODE_W'(NODES - 1) || next_r.fail != r.fail
                        && !r.flags[FLG_AUTO_RECOV]) begin
                        next_r.pstate = POLL_IDLE;
                    end else begin
                        next_r.poll.node = r.poll.node + 1'b1;
                        next_r.poll.req = 1'b1;
                    end
                end
            end
            default: begin
                next_r.pstate = POLL_IDLE;
            end
        endcase

        // Pin level faults pass two flip-flops before use.
        next_r.rf_sync = {r.rf_sync[0], rf_fault_pin};
        next_r.lost_sync = {r.lost_sync[0], sync_lost_pin};
        node_force = (r.flags[FLG_NODE_LINK] && r.rf_sync[1])
            || (r.flags[FLG_SYNC_LOSS] && r.lost_sync[1])
            || (r.flags[FLG_HOST_LINK] && host_timeout)
            || (r.flags[FLG_POWER_UP] && r.pwr_hold);

        // Output drive: one flag set covers every output; hold-last freezes.
        for (int j = 0; j < OUTS; j++) begin
            grp = NODE_W'(j / OUT_PER_NODE);
            if (node_force || (r.flags[FLG_GW_LINK] && r.fail[grp])) begin
                next_r.dig_out[j] = r.flags[FLG_HOLD_LAST] ? r.dig_out[j]
                                                           : r.def_out[j];
            end else begin
                next_r.dig_out[j] = r.sw_out[j];
            end
        end

        // Sample and report interval counters; zero means every tick.
        if (tick) begin
            next_r.samp_cnt = r.samp_cnt + 16'h0001;
            next_r.rep_cnt = r.rep_cnt + 16'h0001;
            if (r.samp_cnt + 16'h0001 >= r.samp_int) begin
                samp_tick = 1'b1;
                next_r.samp_cnt = 16'h0000;
            end
            if (r.rep_cnt + 16'h0001 >= r.rep_int) begin
                rep_tick = 1'b1;
                next_r.rep_cnt = 16'h0000;
            end
        end

        // Analog points: delta filter and threshold with hysteresis.
        for (int i = 0; i < AIN; i++) begin
            if (samp_tick && r.pt_en[i]) begin
                diff = (ana_in[i] >= r.last[i]) ? ana_in[i] - r.last[i]
                                                : r.last[i] - ana_in[i];
                if (r.delta == 16'h0000 || diff >= r.delta) begin
                    next_r.last[i] = ana_in[i];
                end
                off_sum = {1'b0, ana_in[i]} + {1'b0, r.hyst};
                if (ana_in[i] >= r.thr) begin
                    next_r.on[i] = 1'b1;
                end else if (off_sum < {1'b0, r.thr}) begin
                    next_r.on[i] = 1'b0;
                end
            end
            next_r.on_out[i] = r.pt_en[i] && (next_r.on[i] ^ r.pt_inv[i]);
        end

        // Reporting: change of state or periodic, never both.
        if (r.cos) begin
            next_r.report = |((next_r.on ^ r.on) & r.pt_en);
        end else begin
            next_r.report = rep_tick && |r.pt_en;
        end

        // The blocking error is registered so the pin never carries a glitch.
        next_r.err_hold = |(next_r.fail & ~{NODES{next_r.flags[FLG_AUTO_RECOV]}});
    end

    // State register; synchronous reset to constants only.
    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
            r.hready <= 1'b1;
            r.poll_int <= POLL_INT_RST;
            r.max_bad <= MAX_BAD_RST;
            r.relink <= RELINK_RST;
            r.samp_int <= RATE_RST;
            r.rep_int <= RATE_RST;
            r.pwr_hold <= 1'b1;
            r.pstate <= POLL_IDLE;
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_fail_on_bad: assert property (
        (r.pstate == POLL_WAIT && poll_rsp.done && !poll_rsp.ok
         && r.bad[r.poll.node] + 8'h01 >= r.max_bad && r.max_bad != 8'h00)
        |=> r.fail[$past(r.poll.node)]) else $error("node not failed at bad count");
    chk_good_clears_bad: assert property (
        (r.pstate == POLL_WAIT && poll_rsp.done && poll_rsp.ok)
        |=> r.bad[$past(r.poll.node)] == 8'h00) else $error("bad count kept after success");
    chk_relink_clear: assert property (
        (r.pstate == POLL_WAIT && poll_rsp.done && poll_rsp.ok && r.fail[r.poll.node]
         && r.good[r.poll.node] + 8'h01 >= r.relink)
        |=> !r.fail[$past(r.poll.node)]) else $error("link not restored");
    chk_err_holds: assert property (
        (r.fail[1] && !r.flags[FLG_AUTO_RECOV] && !r.wr_pend) |=> r.fail[1])
        else $error("held error dropped without reset");
    chk_reset_clears: assert property (
        (r.wr_pend && r.wr_addr == ADDR_CMD && hwdata[CMD_ERR_RESET]
         && !(r.pstate == POLL_WAIT && poll_rsp.done)) |=> r.fail == '0)
        else $error("reset command left an error");
    chk_no_poll_err: assert property (
        (r.pstate == POLL_IDLE && error_hold) |=> !r.poll.req) else $error("poll while error");
    chk_gw_default: assert property (
        (r.flags[FLG_GW_LINK] && !r.flags[FLG_HOLD_LAST] && r.fail[1])
        |=> r.dig_out[3:2] == $past(r.def_out[3:2])) else $error("failed node not defaulted");
    chk_host_default: assert property (
        (r.flags[FLG_HOST_LINK] && !r.flags[FLG_HOLD_LAST] && host_timeout)
        |=> r.dig_out == $past(r.def_out)) else $error("host timeout not defaulted");
    chk_hold_last: assert property (
        (r.flags[FLG_HOST_LINK] && r.flags[FLG_HOLD_LAST] && host_timeout)
        |=> $stable(r.dig_out)) else $error("hold last changed output");
    chk_disabled_point: assert property (
        !r.pt_en[0] |=> !r.on_out[0] && $stable(r.last[0])) else $error("disabled point moved");

    cov_link_fail: cover property (!r.fail[1] ##1 r.fail[1]);
    cov_recover: cover property (r.flags[FLG_AUTO_RECOV] && r.fail[1] ##1 !r.fail[1]);
    cov_report: cover property (r.cos && r.report);

endmodule : wls_supervisor

// File: test/wls_radio_model.sv
`timescale 1ns/1ps
// Remote radio side of the poll link: answers each poll after a set delay.
module wls_radio_model
    import wls_pkg::*;
(
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             srst,
    // Poll link.
    input  wire wls_poll_req_t    poll_out,
    output wls_poll_rsp_t         poll_rsp,
    // Bench controls and answer counts.
    input  wire logic [NODES-1:0] bad_mask,
    input  wire logic [1:0]       delay,
    output logic [NODES-1:0][7:0] fails,
    output logic [NODES-1:0][7:0] goods
);
    logic              busy;
    logic [1:0]        cnt;
    logic [NODE_W-1:0] node;

    // The ok line toggles between answers, so a stale level never looks like a reply.
    always_ff @(posedge clock) begin
        poll_rsp.done <= 1'b0;
        poll_rsp.ok   <= ~poll_rsp.ok;
        if (srst) begin
            busy        <= 1'b0;
            poll_rsp.ok <= 1'b0;
            fails       <= '0;
            goods       <= '0;
        end else if (poll_out.req) begin
            busy <= 1'b1;
            cnt  <= delay;
            node <= poll_out.node;
        end else if (busy && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (busy) begin
            busy          <= 1'b0;
            poll_rsp.done <= 1'b1;
            poll_rsp.ok   <= ~bad_mask[node];
            fails[node]   <= fails[node] + {7'h00, bad_mask[node]};
            goods[node]   <= goods[node] + {7'h00, ~bad_mask[node]};
        end
    end
endmodule : wls_radio_model

// File: test/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(c) begin for (wn = 0; wn < 4000 && (c) !== 1'b1; wn++) @(posedge clock); \
    if (wn >= 4000) begin miscompares++; finish_test(); end end
module tb_top;
    import wls_pkg::*;
    localparam int TL = 20;
    logic                   clock = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic                   host_timeout = 1'b0, rf_fault_pin = 1'b0, sync_lost_pin = 1'b0;
    logic                   rd_phase = 1'b0, hreadyout, hresp, report_strobe, error_hold;
    logic [1:0]             htrans = 2'h0, delay = 2'h0, ana_on;
    logic [2:0]             hsize = 3'h2;
    logic [31:0]            haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [NODES-1:0]       bad_mask = '0, link_fail;
    logic [AIN-1:0][AW-1:0] ana_in = '0, ana_value;
    logic [OUTS-1:0]        dig_out, sw, dflt;
    logic [NODES-1:0][7:0]  fails, goods;
    logic [7:0]             g0;
    logic [31:0]            exp_q[$];
    wls_poll_req_t          poll_out;
    wls_poll_rsp_t          poll_rsp;
    int                     miscompares = 0, tests_run = 0, seed = 32'h3337;
    int                     wn, req_cnt = 0, strb_cnt = 0, t;
    time                    t0;

    wls_supervisor #(.TICK_LEN(TL)) dut_u (.clock(clock), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .poll_out(poll_out), .poll_rsp(poll_rsp), .host_timeout(host_timeout),
        .rf_fault_pin(rf_fault_pin), .sync_lost_pin(sync_lost_pin), .ana_in(ana_in),
        .dig_out(dig_out), .ana_on(ana_on), .ana_value(ana_value),
        .report_strobe(report_strobe), .link_fail(link_fail), .error_hold(error_hold));
    wls_radio_model radio_u (.clock(clock), .srst(srst), .poll_out(poll_out),
        .poll_rsp(poll_rsp), .bad_mask(bad_mask), .delay(delay), .fails(fails), .goods(goods));

    // Clock, and counts of poll requests and report strobes.
    always #50 clock = ~clock;
    always @(posedge clock) begin
        req_cnt  += (poll_out.req === 1'b1);
        strb_cnt += (report_strobe === 1'b1);
        delay    <= 2'($random(seed));
    end

    // Read data is checked against the oldest note at the edge ending the data phase.
    always @(posedge clock) begin
        if (rd_phase && hreadyout === 1'b1) begin
            `CHK("hrdata", exp_q[0], hrdata)
            void'(exp_q.pop_front());
        end
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // One bus phase ends at the first edge with ready high.
    task automatic ready_edge;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            finish_test();
        end
    endtask : ready_edge

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        ready_edge();
        hsel     <= 1'b0;
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= !w;
        ready_edge();
        rd_phase <= 1'b0;
    endtask : bus

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, ~e);
    endtask : rd

    // Main sequence; the poll interval is set early so its counter is still below it.
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(ADDR_POLL, 32'h0407_03E8);
        bus(1'b1, ADDR_POLL, 32'h0203_0002);
        rd(ADDR_RATE, 32'h0001_0000);
        rd(ADDR_REPORT, 32'h0000_0001);
        rd(ADDR_CMD, 32'h0000_0000);
        rd(32'h0000_0030, 32'h0000_0000);
        `WAITFOR(poll_out.req && poll_out.node == 2'h0)
        t0 = $time;
        @(posedge clock);
        `WAITFOR(poll_out.req && poll_out.node == 2'h0)
        `CHK("poll interval", 64'(2 * TL * 100), $time - t0)
        // A good reply between failures restarts the run of failures.
        bad_mask <= 4'b0010;
        `WAITFOR(fails[1] == 8'h02)
        bad_mask <= 4'b0000;
        g0 = goods[1];
        `WAITFOR(goods[1] != g0)
        bad_mask <= 4'b0010;
        `WAITFOR(link_fail[1])
        `CHK("fails", 8'h05, fails[1])
        `CHK("error_hold", 1'b1, error_hold)
        t = req_cnt;
        repeat (10 * TL) @(posedge clock);
        `CHK("poll count", t, req_cnt)
        rd(ADDR_STATUS, 32'h0000_0012);
        bad_mask <= 4'b0000;
        bus(1'b1, ADDR_CMD, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0000);
        sw   = 8'($random(seed));
        dflt = 8'($random(seed));
        bus(1'b1, ADDR_OUTS, {16'h0000, dflt, sw});
        bus(1'b1, ADDR_FLAGS, 32'h0000_0004);
        bad_mask <= 4'b0010;
        `WAITFOR(link_fail[1])
        repeat (2) @(posedge clock);
        `CHK("dig_out", {sw[7:4], dflt[3:2], sw[1:0]}, dig_out)
        bad_mask <= 4'b0000;
        g0 = goods[1];
        bus(1'b1, ADDR_FLAGS, 32'h0000_0024);
        `WAITFOR(link_fail[1] == 1'b0)
        `CHK("goods", 8'h02, 8'(goods[1] - g0))
        // Host timeout, own radio fault and sync loss each force the defaults.
        bus(1'b1, ADDR_FLAGS, 32'h0000_003A);
        for (int k = 0; k < 3; k++) begin
            {sync_lost_pin, rf_fault_pin, host_timeout} <= 3'b001 << k;
            repeat (5) @(posedge clock);
            `CHK("dig_out", dflt, dig_out)
            {sync_lost_pin, rf_fault_pin, host_timeout} <= 3'b000;
            repeat (5) @(posedge clock);
            `CHK("dig_out", sw, dig_out)
        end
        bus(1'b1, ADDR_FLAGS, 32'h0000_007A);
        host_timeout <= 1'b1;
        repeat (5) @(posedge clock);
        `CHK("dig_out", sw, dig_out)
        host_timeout <= 1'b0;
        // Threshold 100, hysteresis 20, point 1 inverted.
        bus(1'b1, ADDR_THRESH, 32'h0014_0064);
        bus(1'b1, ADDR_RATE, 32'h0000_0000);
        bus(1'b1, ADDR_POINT, 32'h0000_000B);
        ana_in <= {16'h0000, 16'h0064};
        repeat (3 * TL) @(posedge clock);
        `CHK("ana_on", 2'b11, ana_on)
        `CHK("ana_value", 16'h0064, ana_value[0])
        ana_in[0] <= 16'h0050;
        repeat (3 * TL) @(posedge clock);
        `CHK("ana_on", 1'b1, ana_on[0])
        ana_in[0] <= 16'h004F;
        repeat (3 * TL) @(posedge clock);
        `CHK("ana_on", 1'b0, ana_on[0])
        bus(1'b1, ADDR_RATE, 32'h0000_0032);
        ana_in[0] <= 16'h0070;
        repeat (3 * TL) @(posedge clock);
        `CHK("ana_value", 16'h004F, ana_value[0])
        bus(1'b1, ADDR_POINT, 32'h0000_000A);
        ana_in[0] <= 16'h00C8;
        repeat (3 * TL) @(posedge clock);
        `CHK("ana_on", 1'b0, ana_on[0])
        bus(1'b1, ADDR_REPORT, 32'h0000_0003);
        `WAITFOR(report_strobe)
        @(posedge clock);
        `WAITFOR(report_strobe)
        t0 = $time;
        @(posedge clock);
        `WAITFOR(report_strobe)
        `CHK("report period", 64'(3 * TL * 100), $time - t0)
        // Change-of-state mode: silent while steady, one report on a crossing.
        bus(1'b1, ADDR_REPORT, 32'h0001_0001);
        repeat (3 * TL) @(posedge clock);
        t = strb_cnt;
        repeat (6 * TL) @(posedge clock);
        `CHK("strobes", t, strb_cnt)
        ana_in[1] <= 16'h0080;
        repeat (6 * TL) @(posedge clock);
        `CHK("strobes", t + 1, strb_cnt)
        rd(ADDR_VALUE, 32'h0080_004F);
        finish_test();
    end
endmodule : tb_top
